// *** hw/dispense_device.sv ***
// Dispensing device end: decodes command pulse widths and runs strokes.
// Assumes motor sense and pressure inputs are asynchronous to i_clock.
//
// Contract
// - High 1.9 to 2.1 s is one stroke
// - One-stroke command gives one motor run
// - High 2.9 to 3.1 s is two strokes
// - Two-stroke command gives two separate motor runs
// - Fill command gives 40 runs in succession
// - Status held high while ready, no error
// - Accept only after status high over 3 s
// - Run starts at falling edge; status low throughout
// - Run end taken from motor feedback
// - Faultless run returns status high
// - Ignore commands until 3 s after run
// - Controller spaces one-stroke commands 22 s
// - Controller spaces two-stroke commands 41 s
// - Ready code flashes while command held high
// - Green lit and pressure shown during run
// - Green blinks once per 5 s when ready
// - Fault drives error status, red flashes
// - High 11.9 to 12.1 s is fill
// - Status high 0.5 s between strokes
// - Other widths ignored; over 15 s shows dash
`timescale 1ns/10ps
module dispense_device #(
  parameter int unsigned TICK_CYCLES = dispense_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // Link to the controller
  dispense_link_if.device link,
  // Motor sense and drive
  input  wire logic       i_motor_done,
  input  wire logic       i_motor_fault,
  input  wire logic [5:0] i_pressure,
  output logic            o_motor_run,
  // Display and indicators
  output logic            o_led_green,
  output logic            o_led_red,
  output logic            o_ready_code_flash,
  output logic            o_dash_shown,
  output logic [5:0]      o_display_value
);

  typedef enum logic [2:0] {
    ST_WAIT, ST_ARMED, ST_PULSE, ST_RUN, ST_GAP, ST_FAULT
  } dev_state_t;

  typedef struct packed {
    logic                 cmd_m;
    logic                 cmd_s;
    logic                 cmd_p;
    logic                 done_m;
    logic                 done_s;
    logic                 done_p;
    logic                 flt_m;
    logic                 flt_s;
    logic [5:0]           prs_m;
    logic [5:0]           prs_s;
    logic [16:0]          div;
    logic                 tick;
    dev_state_t           st;
    dispense_pkg::ticks_t t;
    dispense_pkg::ticks_t blink;
    logic [5:0]           left;
    logic                 status;
    logic                 motor;
    logic                 green;
    logic                 red;
    logic                 flash;
    logic                 dash;
    logic [5:0]           value;
  } dev_t;

  dev_t s_q;
  dev_t s_d;

  // Strokes for a measured width; zero when outside every band
  function automatic logic [5:0] strokes_of(input dispense_pkg::ticks_t w);
    logic [5:0] r;
    r = 6'h00;
    if (w >= dispense_pkg::ONE_MIN_T && w <= dispense_pkg::ONE_MAX_T)
      r = dispense_pkg::ONE_STROKES;
    if (w >= dispense_pkg::TWO_MIN_T && w <= dispense_pkg::TWO_MAX_T)
      r = dispense_pkg::TWO_STROKES;
    if (w >= dispense_pkg::FILL_MIN_T && w <= dispense_pkg::FILL_MAX_T)
      r = dispense_pkg::FILL_STROKES;
    return r;
  endfunction

  function automatic logic [5:0] clamp_press(input logic [5:0] p);
    logic [5:0] r;
    r = p;
    if (p < dispense_pkg::PRESS_MIN)
      r = dispense_pkg::PRESS_MIN;
    if (p > dispense_pkg::PRESS_MAX)
      r = dispense_pkg::PRESS_MAX;
    return r;
  endfunction

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;

    // Two-flop synchronisers; first stages feed nothing else
    s_d.cmd_m  = link.cmd;
    s_d.cmd_s  = s_q.cmd_m;
    s_d.cmd_p  = s_q.cmd_s;
    s_d.done_m = i_motor_done;
    s_d.done_s = s_q.done_m;
    s_d.done_p = s_q.done_s;
    s_d.flt_m  = i_motor_fault;
    s_d.flt_s  = s_q.flt_m;
    s_d.prs_m  = i_pressure;
    s_d.prs_s  = s_q.prs_m;

    // 10 ms timebase
    if (s_q.div == 17'(TICK_CYCLES - 1)) begin
      s_d.div  = 17'h00000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 17'h00001;
    end

    // Free-running 5 s blink phase
    if (s_q.tick) begin
      if (s_q.blink >= dispense_pkg::BLINK_T - 1'b1)
        s_d.blink = '0;
      else
        s_d.blink = s_q.blink + 1'b1;
    end

    s_d.flash = 1'b0;
    s_d.red   = 1'b0;
    s_d.value = 6'h00;

    unique case (s_q.st)
      ST_WAIT: begin
        // Holdoff after power-on or a run; pulses here are ignored
        s_d.status = 1'b1;
        s_d.motor  = 1'b0;
        s_d.green  = s_q.blink < dispense_pkg::LED_ON_T;
        if (!s_q.status)
          s_d.t = '0;
        else if (s_q.tick && s_q.t <= dispense_pkg::READY_T)
          s_d.t = s_q.t + 1'b1;
        // A pulse already high at the end of holdoff is not taken
        if (s_q.flt_s)
          s_d.st = ST_FAULT;
        else if (s_q.t > dispense_pkg::READY_T && !s_q.cmd_s)
          s_d.st = ST_ARMED;
      end
      ST_ARMED: begin
        s_d.status = 1'b1;
        s_d.green  = s_q.blink < dispense_pkg::LED_ON_T;
        if (s_q.flt_s) begin
          s_d.st = ST_FAULT;
        end else if (s_q.cmd_s && !s_q.cmd_p) begin
          s_d.st   = ST_PULSE;
          s_d.t    = '0;
          s_d.dash = 1'b0;
        end
      end
      ST_PULSE: begin
        s_d.status = 1'b1;
        s_d.green  = s_q.blink < dispense_pkg::LED_ON_T;
        s_d.flash  = s_q.cmd_s;
        // Saturate just past the dash limit so the count never wraps
        if (s_q.tick && s_q.t <= dispense_pkg::DASH_T)
          s_d.t = s_q.t + 1'b1;
        if (s_q.t > dispense_pkg::DASH_T)
          s_d.dash = 1'b1;
        if (!s_q.cmd_s) begin
          if (strokes_of(s_q.t) != 6'h00 && !s_q.dash) begin
            s_d.st     = ST_RUN;
            s_d.left   = strokes_of(s_q.t);
            s_d.motor  = 1'b1;
            s_d.status = 1'b0;
            s_d.green  = 1'b1;
          end else begin
            s_d.st = ST_ARMED;
          end
        end
      end
      ST_RUN: begin
        s_d.status = 1'b0;
        s_d.motor  = 1'b1;
        s_d.green  = 1'b1;
        s_d.value  = clamp_press(s_q.prs_s);
        if (s_q.flt_s) begin
          s_d.st    = ST_FAULT;
          s_d.motor = 1'b0;
        end else if (s_q.done_s && !s_q.done_p) begin
          s_d.motor  = 1'b0;
          s_d.status = 1'b1;
          s_d.t      = '0;
          s_d.value  = 6'h00;
          if (s_q.left > 6'h01) begin
            s_d.left = s_q.left - 6'h01;
            s_d.st   = ST_GAP;
          end else begin
            s_d.left = 6'h00;
            s_d.st   = ST_WAIT;
          end
        end
      end
      ST_GAP: begin
        s_d.status = 1'b1;
        s_d.green  = 1'b0;
        if (s_q.tick)
          s_d.t = s_q.t + 1'b1;
        if (s_q.flt_s) begin
          s_d.st = ST_FAULT;
        end else if (s_q.t >= dispense_pkg::GAP_T) begin
          s_d.st     = ST_RUN;
          s_d.motor  = 1'b1;
          s_d.status = 1'b0;
          s_d.green  = 1'b1;
        end
      end
      ST_FAULT: begin
        // Held until reset; nothing else leaves this state
        s_d.status = 1'b0;
        s_d.motor  = 1'b0;
        s_d.green  = 1'b0;
        // Red period is two lit spells long, lit for the first half
        s_d.red    = (s_q.blink % {dispense_pkg::LED_ON_T, 1'b0})
                     < dispense_pkg::LED_ON_T;
      end
      default: begin
        s_d.st = ST_FAULT;
      end
    endcase

    if (i_sys_rst) begin
      s_d        = '0;
      s_d.st     = ST_WAIT;
      s_d.status = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    s_q <= s_d;
  end

  assign link.status        = s_q.status;
  assign o_motor_run        = s_q.motor;
  assign o_led_green        = s_q.green;
  assign o_led_red          = s_q.red;
  assign o_ready_code_flash = s_q.flash;
  assign o_dash_shown       = s_q.dash;
  assign o_display_value    = s_q.value;

endmodule

// *** hw/dispense_pkg.sv ***
// Shared constants and types for the pulse-width dispense command link.
// Assumes a single 10 MHz system clock on both ends.
package dispense_pkg;

  // Clock and timebase
  localparam int CLOCK_NS    = 100;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = TICK_MS * 1000000 / CLOCK_NS;

  // Time counters are kept in timebase ticks
  localparam int TW = 17;
  typedef logic [TW-1:0] ticks_t;

  // Command bands and device timings, milliseconds as specified
  localparam int ONE_MIN_MS  = 1900;
  localparam int ONE_MAX_MS  = 2100;
  localparam int TWO_MIN_MS  = 2900;
  localparam int TWO_MAX_MS  = 3100;
  localparam int FILL_MIN_MS = 11900;
  localparam int FILL_MAX_MS = 12100;
  localparam int DASH_MS     = 15000;
  localparam int READY_MS    = 3000;
  localparam int GAP_MS      = 500;
  localparam int BLINK_MS    = 5000;
  localparam int LED_ON_MS   = 500;

  // Controller pulse widths and least spacing between commands
  localparam int ONE_W_MS     = 2000;
  localparam int TWO_W_MS     = 3000;
  localparam int FILL_W_MS    = 12000;
  localparam int ONE_SP_MS    = 22000;
  localparam int TWO_SP_MS    = 41000;
  localparam int FILL_SP_MS   = 706000;

  // Least times round up, longest times round down
  function automatic ticks_t ceil_ticks(input int ms);
    return ticks_t'((ms + TICK_MS - 1) / TICK_MS);
  endfunction

  function automatic ticks_t floor_ticks(input int ms);
    return ticks_t'(ms / TICK_MS);
  endfunction

  localparam ticks_t ONE_MIN_T  = ceil_ticks(ONE_MIN_MS);
  localparam ticks_t ONE_MAX_T  = floor_ticks(ONE_MAX_MS);
  localparam ticks_t TWO_MIN_T  = ceil_ticks(TWO_MIN_MS);
  localparam ticks_t TWO_MAX_T  = floor_ticks(TWO_MAX_MS);
  localparam ticks_t FILL_MIN_T = ceil_ticks(FILL_MIN_MS);
  localparam ticks_t FILL_MAX_T = floor_ticks(FILL_MAX_MS);
  localparam ticks_t DASH_T     = floor_ticks(DASH_MS);
  localparam ticks_t READY_T    = floor_ticks(READY_MS);
  localparam ticks_t GAP_T      = ceil_ticks(GAP_MS);
  localparam ticks_t BLINK_T    = floor_ticks(BLINK_MS);
  localparam ticks_t LED_ON_T   = floor_ticks(LED_ON_MS);
  localparam ticks_t ONE_W_T    = floor_ticks(ONE_W_MS);
  localparam ticks_t TWO_W_T    = floor_ticks(TWO_W_MS);
  localparam ticks_t FILL_W_T   = floor_ticks(FILL_W_MS);
  localparam ticks_t ONE_SP_T   = ceil_ticks(ONE_SP_MS);
  localparam ticks_t TWO_SP_T   = ceil_ticks(TWO_SP_MS);
  localparam ticks_t FILL_SP_T  = ceil_ticks(FILL_SP_MS);

  // Strokes per command
  localparam logic [5:0] ONE_STROKES  = 6'h01;
  localparam logic [5:0] TWO_STROKES  = 6'h02;
  localparam logic [5:0] FILL_STROKES = 6'h28;

  // Counterpressure display range
  localparam logic [5:0] PRESS_MIN = 6'h01;
  localparam logic [5:0] PRESS_MAX = 6'h32;

  typedef enum logic [1:0] {CMD_NONE, CMD_ONE, CMD_TWO, CMD_FILL} cmd_kind_t;

endpackage

// *** hw/dispense_link_if.sv ***
// Single-wire command line and level-coded status line.
// Both lines are plain one-direction wires; each end syncs what it reads.
`timescale 1ns/10ps
interface dispense_link_if;
  logic cmd;
  logic status;

  modport device     (input cmd, output status);
  modport controller (output cmd, input status);
endinterface

// *** hw/dispense_controller.sv ***
// Controller end: turns command requests into timed high pulses.
// Assumes the status line is asynchronous; it is synced before use.
`timescale 1ns/10ps
module dispense_controller #(
  parameter int unsigned TICK_CYCLES = dispense_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_sys_rst,
  // Link to the device
  dispense_link_if.controller          link,
  // User request side
  input  wire logic                    i_cmd_req,
  input  wire dispense_pkg::cmd_kind_t i_cmd_kind,
  output logic                         o_ready,
  output logic                         o_busy,
  output logic                         o_status_seen
);

  typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_SPACE} ctl_state_t;

  typedef struct packed {
    logic                 sts_m;
    logic                 sts_s;
    logic [16:0]          div;
    logic                 tick;
    ctl_state_t           st;
    dispense_pkg::ticks_t t;
    dispense_pkg::ticks_t ok;
    dispense_pkg::ticks_t width;
    dispense_pkg::ticks_t space;
    logic                 cmd;
    logic                 ready;
    logic                 busy;
  } ctl_t;

  ctl_t c_q;
  ctl_t c_d;

  always_comb begin
    c_d       = c_q;
    c_d.tick  = 1'b0;
    c_d.sts_m = link.status;
    c_d.sts_s = c_q.sts_m;

    if (c_q.div == 17'(TICK_CYCLES - 1)) begin
      c_d.div  = 17'h00000;
      c_d.tick = 1'b1;
    end else begin
      c_d.div = c_q.div + 17'h00001;
    end

    // Status must have stood high without a break for over 3 s
    if (!c_q.sts_s)
      c_d.ok = '0;
    else if (c_q.tick && c_q.ok <= dispense_pkg::READY_T)
      c_d.ok = c_q.ok + 1'b1;

    unique case (c_q.st)
      ST_IDLE: begin
        if (i_cmd_req && c_q.ready && i_cmd_kind != dispense_pkg::CMD_NONE)
        begin
          c_d.st  = ST_DRIVE;
          c_d.t   = '0;
          c_d.cmd = 1'b1;
          unique case (i_cmd_kind)
            dispense_pkg::CMD_ONE: begin
              c_d.width = dispense_pkg::ONE_W_T;
              c_d.space = dispense_pkg::ONE_SP_T;
            end
            dispense_pkg::CMD_TWO: begin
              c_d.width = dispense_pkg::TWO_W_T;
              c_d.space = dispense_pkg::TWO_SP_T;
            end
            default: begin
              c_d.width = dispense_pkg::FILL_W_T;
              c_d.space = dispense_pkg::FILL_SP_T;
            end
          endcase
        end
      end
      ST_DRIVE: begin
        if (c_q.tick)
          c_d.t = c_q.t + 1'b1;
        if (c_q.t >= c_q.width) begin
          c_d.cmd = 1'b0;
          c_d.st  = ST_SPACE;
          c_d.t   = '0;
        end
      end
      ST_SPACE: begin
        // Spacing counted from the falling edge: a conservative reading
        if (c_q.tick)
          c_d.t = c_q.t + 1'b1;
        // One tick over: the first tick may come just after the edge
        if (c_q.t > c_q.space)
          c_d.st = ST_IDLE;
      end
      default: begin
        c_d.st = ST_IDLE;
      end
    endcase

    c_d.busy  = c_d.st != ST_IDLE;
    c_d.ready = c_d.st == ST_IDLE && c_d.ok > dispense_pkg::READY_T;

    if (i_sys_rst)
      c_d = '0;
  end

  always_ff @(posedge i_clock) begin
    c_q <= c_d;
  end

  assign link.cmd      = c_q.cmd;
  assign o_ready       = c_q.ready;
  assign o_busy        = c_q.busy;
  assign o_status_seen = c_q.sts_s;

endmodule

// *** sim/dispense_link_props.sv ***
// Checker: timing relations on the command and status wires of one link.
// Assumes both wires come from the two design ends, with no fault injected.
`timescale 1ns/10ps
module dispense_link_props #(
  parameter int unsigned TICK_CYCLES = dispense_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Link wires
  input wire logic cmd,
  input wire logic status
);
  localparam int TK  = TICK_CYCLES;
  localparam int W1L = dispense_pkg::ONE_MIN_T * TK;
  localparam int W1H = dispense_pkg::ONE_MAX_T * TK;
  localparam int W2L = dispense_pkg::TWO_MIN_T * TK;
  localparam int W2H = dispense_pkg::TWO_MAX_T * TK;
  localparam int WFL = dispense_pkg::FILL_MIN_T * TK;
  localparam int WFH = dispense_pkg::FILL_MAX_T * TK;
  localparam int RDY = dispense_pkg::READY_T * TK;
  localparam int GAP = dispense_pkg::GAP_T * TK;
  localparam int SP1 = dispense_pkg::ONE_SP_T * TK;
  localparam int SP2 = dispense_pkg::TWO_SP_T * TK;
  localparam int SPF = dispense_pkg::FILL_SP_T * TK;

  int hi_q;
  int st_q;
  int lo_q;
  int fall_q;
  int last_q;

  // Cycle counts; no reset needed as each restarts on a wire level or reloads when cmd falls
  always_ff @(posedge i_clock) begin
    hi_q   <= cmd ? hi_q + 1 : 0;
    st_q   <= status ? st_q + 1 : 0;
    lo_q   <= status ? 0 : lo_q + 1;
    fall_q <= (!cmd && hi_q != 0) ? 0 : fall_q + 1;
    last_q <= (!cmd && hi_q != 0) ? hi_q : last_q;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  AST_CMD_BAND: assert property ($fell(cmd) |->
    (hi_q >= W1L && hi_q <= W1H) || (hi_q >= W2L && hi_q <= W2H) ||
    (hi_q >= WFL && hi_q <= WFH))
    else $error("command pulse width outside every band");
  AST_ARMED: assert property ($rose(cmd) |-> st_q > RDY)
    else $error("command sent before status high long enough");
  AST_SPACING: assert property ($rose(cmd) && last_q != 0 |->
    fall_q >= (last_q < W2L ? SP1 : last_q < WFL ? SP2 : SPF))
    else $error("commands spaced too closely");
  AST_READY_LEVEL: assert property (cmd |-> status)
    else $error("status low while command held");
  AST_RUN_START: assert property ($fell(cmd) |-> ##[1:4] !status)
    else $error("run not started at end of command");
  AST_LOW_CAUSE: assert property ($fell(status) |-> fall_q <= 6 ||
    (st_q >= GAP - TK && st_q <= GAP + TK))
    else $error("status fell without command or pause end");
  AST_RUN_HOLDS: assert property ($fell(status) |=> !status [*8])
    else $error("run ended before motor feedback");
  // Bench motor answers 40 cycles into each run
  AST_RUN_ENDS: assert property (lo_q <= 64)
    else $error("status not returned high after run");

  cover property ($fell(cmd));
  cover property ($fell(status) && fall_q > 6);
  cover property ($rose(cmd) && last_q != 0);
endmodule

// *** sim/pulse_width_dispense_command_tb_top.sv ***
// Bench: controller and device joined by one link, plus a second device
// whose command wire the bench drives by hand with bad and odd pulses.
`timescale 1ns/10ps
module pulse_width_dispense_command_tb_top;
  localparam int TK = 10;

  logic                    i_clock;
  logic                    i_sys_rst = 1'b1;
  logic                    cmd_req   = 1'b0;
  dispense_pkg::cmd_kind_t cmd_kind  = dispense_pkg::CMD_NONE;
  logic [5:0]              pressure  = 6'h3F;
  logic                    fault_b   = 1'b0;
  logic                    done_a    = 1'b0;
  logic                    done_b    = 1'b0;
  logic                    run_a;
  logic                    run_b;
  logic                    green_a;
  logic                    flash_a;
  logic                    red_b;
  logic                    dash_b;
  logic                    ready;
  logic                    busy;
  logic                    seen;
  logic [5:0]              disp_a;
  int                      cnt_a      = 0;
  int                      cnt_b      = 0;
  int                      runs_a     = 0;
  int                      runs_b     = 0;
  int                      n_mismatch = 0;
  int                      cmp_count  = 0;

  dispense_link_if link();
  dispense_link_if link_b();

  dispense_controller #(.TICK_CYCLES(TK)) u_dispense_controller (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .link          (link.controller),
    .i_cmd_req     (cmd_req),
    .i_cmd_kind    (cmd_kind),
    .o_ready       (ready),
    .o_busy        (busy),
    .o_status_seen (seen)
  );

  dispense_device #(.TICK_CYCLES(TK)) u_dispense_device (
    .i_clock            (i_clock),
    .i_sys_rst          (i_sys_rst),
    .link               (link.device),
    .i_motor_done       (done_a),
    .i_motor_fault      (1'b0),
    .i_pressure         (pressure),
    .o_motor_run        (run_a),
    .o_led_green        (green_a),
    .o_led_red          (),
    .o_ready_code_flash (flash_a),
    .o_dash_shown       (),
    .o_display_value    (disp_a)
  );

  dispense_device #(.TICK_CYCLES(TK)) u_dispense_device_b (
    .i_clock            (i_clock),
    .i_sys_rst          (i_sys_rst),
    .link               (link_b.device),
    .i_motor_done       (done_b),
    .i_motor_fault      (fault_b),
    .i_pressure         (pressure),
    .o_motor_run        (run_b),
    .o_led_green        (),
    .o_led_red          (red_b),
    .o_ready_code_flash (),
    .o_dash_shown       (dash_b),
    .o_display_value    ()
  );

  dispense_link_props #(.TICK_CYCLES(TK)) u_dispense_link_props (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .cmd       (link.cmd),
    .status    (link.status)
  );

  // Motor feedback: each run completes 40 cycles in, far shorter than real
  always @(posedge i_clock) begin
    cnt_a  <= run_a ? cnt_a + 1 : 0;
    cnt_b  <= run_b ? cnt_b + 1 : 0;
    done_a <= run_a && cnt_a >= 40;
    done_b <= run_b && cnt_b >= 40;
    if (run_a && cnt_a == 0) runs_a <= runs_a + 1;
    if (run_b && cnt_b == 0) runs_b <= runs_b + 1;
  end

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic step(inout int n);
    @(posedge i_clock);
    #1;
    n++;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_ready;
    int n;
    int g;
    n = 0;
    g = 0;
    // Blink phase restarts at reset, so one lit spell falls in this span
    while (n < 2900) begin
      step(n);
      if (green_a === 1'b1) g++;
    end
    g = g - dispense_pkg::LED_ON_T * TK;
    chk(g >= -TK && g <= TK, 1'b1);
    chk(ready, 1'b0);
    chk(link.status, 1'b1);
    n = 0;
    while (ready !== 1'b1 && n < 400) step(n);
    chk(ready, 1'b1);
    $display("test ready done");
  endtask

  task automatic t_cmd(input dispense_pkg::cmd_kind_t k, input int w,
                       input int sp, input int nr, input logic [5:0] p,
                       input logic [5:0] dv);
    int n;
    int r0;
    r0 = runs_a;
    @(posedge i_clock);
    pressure <= p;
    cmd_req  <= 1'b1;
    cmd_kind <= k;
    @(posedge i_clock);
    cmd_req <= 1'b0;
    #1;
    n = 0;
    while (link.cmd !== 1'b1 && n < 10) step(n);
    tick(100);
    #1;
    chk(flash_a, 1'b1);
    n = 100;
    while (link.cmd === 1'b1 && n < 13000) step(n);
    chk(n >= (w - 1) * TK && n <= (w + 1) * TK, 1'b1);
    tick(10);
    #1;
    chk(run_a, 1'b1);
    chk(link.status, 1'b0);
    chk(green_a, 1'b1);
    chk(disp_a, dv);
    chk(busy, 1'b1);
    chk(seen, 1'b0);
    n = 10;
    while (ready !== 1'b1 && n < 45000) step(n);
    chk(n >= sp * TK, 1'b1);
    chk(runs_a - r0, nr);
    chk(link.status, 1'b1);
    chk(busy, 1'b0);
    chk(seen, 1'b1);
    $display("test command %0d done", k);
  endtask

  // Hand-made pulse on the second link; hold covers runs and holdoff
  task automatic t_pulse_b(input int w, input int nr, input logic dash,
                           input int hold);
    int r0;
    r0 = runs_b;
    @(posedge i_clock);
    link_b.cmd <= 1'b1;
    tick(w * TK);
    link_b.cmd <= 1'b0;
    tick(hold);
    #1;
    chk(runs_b - r0, nr);
    chk(dash_b, dash);
    $display("test pulse %0d ticks done", w);
  endtask

  task automatic t_fault_b;
    logic r;
    @(posedge i_clock);
    fault_b <= 1'b1;
    tick(5);
    #1;
    chk(link_b.status, 1'b0);
    r = red_b;
    tick(dispense_pkg::LED_ON_T * TK);
    #1;
    chk(red_b, !r);
    chk(link_b.status, 1'b0);
    $display("test fault done");
  endtask

  initial begin
    link_b.cmd = 1'b0;
    tick(12);
    i_sys_rst <= 1'b0;
    fork
      begin
        t_ready();
        t_cmd(dispense_pkg::CMD_ONE, dispense_pkg::ONE_W_T,
              dispense_pkg::ONE_SP_T, 1, 6'h3F, dispense_pkg::PRESS_MAX);
        t_cmd(dispense_pkg::CMD_TWO, dispense_pkg::TWO_W_T,
              dispense_pkg::TWO_SP_T, 2, 6'h00, dispense_pkg::PRESS_MIN);
      end
      begin
        t_pulse_b(200, 0, 1'b0, 3400);
        t_pulse_b(188, 0, 1'b0, 20);
        t_pulse_b(250, 0, 1'b0, 20);
        t_pulse_b(1600, 0, 1'b1, 20);
        t_pulse_b(192, 1, 1'b0, 3600);
        t_pulse_b(308, 2, 1'b0, 4200);
        t_pulse_b(1200, 40, 1'b0, 25000);
        t_fault_b();
      end
    join
    results();
  end

  // Both sequences finish before 77000 cycles
  initial begin
    tick(90000);
    n_mismatch++;
    results();
  end
endmodule
